// ---- adc_host_ctrl.sv ----
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Purpose: Host end; runs conversions and reads both results over AHB-Lite
// Assumes: Single word transfers, slave answers with zero wait states
// Notes:   CTRL write bit0 starts a conversion, bit1 writes config, bit2 DAC
module adc_host_ctrl
	import adc_ctrl_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	adc_link_if.host         link,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata
);
	typedef enum logic [2:0] {H_IDLE, H_WR, H_SETUP, H_CONV, H_WAIT, H_RD, H_GAP} host_state_t;
	host_state_t       state;
	logic              wrPend;
	logic [7:0]        addrQ;
	logic [DATA_W-1:0] cfgReg, dacReg, resA, resB;
	logic [2:0]        cmd;
	logic [3:0]        cnt;
	logic              busyS1, busyS2, rdSecond;
	logic              bsyPrev;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wrPend <= 1'b0;
			addrQ  <= '0;
		end else begin
			wrPend <= hsel & htrans[1] & hwrite & hready;
			addrQ  <= haddr[7:0];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busyS1  <= 1'b0;
			busyS2  <= 1'b0;
			bsyPrev <= 1'b0;
		end else begin
			busyS1  <= link.busy;
			busyS2  <= busyS1;
			bsyPrev <= busyS2;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfgReg <= CFG_RESET;
			dacReg <= {2'b00, DAC_RESET};
		end else if (wrPend && addrQ == REG_CFG) begin
			cfgReg <= hwdata[DATA_W-1:0];
		end else if (wrPend && addrQ == REG_DAC) begin
			dacReg <= {2'b00, hwdata[DAC_W-1:0]};
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state            <= H_IDLE;
			cmd              <= '0;
			cnt              <= '0;
			rdSecond         <= 1'b0;
			resA             <= '0;
			resB             <= '0;
			link.convStart_n <= 1'b1;
			link.chipSel_n   <= 1'b1;
			link.rd_n        <= 1'b1;
			link.wr_n        <= 1'b1;
			link.hostData    <= '0;
			link.hostDataOe  <= 1'b0;
		end else begin
			unique case (state)
				H_IDLE: begin
					if (wrPend && addrQ == REG_CTRL && hwdata[2:0] != 3'd0 && !busyS2) begin
						cmd   <= hwdata[2:0];
						state <= H_WR;
						cnt   <= '0;
					end
				end
				H_WR: begin
					cnt <= cnt + 4'd1;
					if (cmd[2:1] == 2'b00) begin
						state <= H_SETUP;
						cnt   <= '0;
					end else if (cnt == 4'd0) begin
						link.chipSel_n  <= 1'b0;
						link.wr_n       <= 1'b0;
						link.hostDataOe <= 1'b1;
						link.hostData   <= cmd[1] ? cfgReg : {1'b1, dacReg[DATA_W-2:0]};
					end else if (cnt == 4'd2) begin
						link.wr_n <= 1'b1;
					end else if (cnt == 4'd6) begin
						// Data must outlast the far end's two-flop delay on the strobe
						link.chipSel_n  <= 1'b1;
						link.hostDataOe <= 1'b0;
						if (cmd[1])
							cmd[1] <= 1'b0;
						else
							cmd[2] <= 1'b0;
						cnt             <= '0;
					end
				end
				H_SETUP: begin
					cnt <= cnt + 4'd1;
					if (!cmd[0]) begin
						state <= H_IDLE;
					end else if (cnt >= 4'(CFG_SETUP_CYC + ACQ_CYCLES)) begin
						link.convStart_n <= 1'b0;
						state            <= H_CONV;
						cnt              <= '0;
					end
				end
				H_CONV: begin
					cnt <= cnt + 4'd1;
					if (cnt == 4'd1)
						link.convStart_n <= 1'b1;
					if (busyS2 && !bsyPrev)
						state <= H_WAIT;
				end
				H_WAIT: if (!busyS2) begin
					link.chipSel_n <= 1'b0;
					link.rd_n      <= 1'b0;
					rdSecond       <= 1'b0;
					cnt            <= '0;
					state          <= H_RD;
				end
				H_RD: begin
					cnt <= cnt + 4'd1;
					if (cnt == 4'd4) begin
						if (rdSecond) resB <= link.busLevel;
						else resA <= link.busLevel;
						link.rd_n <= 1'b1;
					end else if (cnt == 4'd7) begin
						cnt <= '0;
						if (rdSecond) begin
							link.chipSel_n <= 1'b1;
							state          <= H_GAP;
						end else begin
							link.rd_n <= 1'b0;
							rdSecond  <= 1'b1;
						end
					end
				end
				H_GAP: state <= H_IDLE;
				default: state <= H_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hrdata <= '0;
		end else if (hsel && htrans[1] && !hwrite && hready) begin
			unique case (haddr[7:0])
				REG_CFG:    hrdata <= {20'h00000, cfgReg};
				REG_DAC:    hrdata <= {20'h00000, dacReg};
				REG_STATUS: hrdata <= {28'h0000000, busyS2, 2'b00, state != H_IDLE};
				REG_RESULT: hrdata <= {4'h0, resB, 4'h0, resA};
				default:    hrdata <= 32'h00000000;
			endcase
		end
	end
endmodule : adc_host_ctrl

// ---- adc_ctrl_pkg.sv ----
// Purpose: Shared constants for the dual converter control link
// Assumes: One 20 MHz system clock on both ends
// Notes:   Configuration field layout beyond channel select is local choice
package adc_ctrl_pkg;
	localparam int  DATA_W        = 12;
	localparam int  DAC_W         = 10;
	localparam real CLK_PERIOD_NS = 50.0;
	localparam int  CONV_CLOCKS   = 13;
	localparam int  BUSY_DROP_EDGE = 14;
	localparam real ACQ_NS        = 62.5;
	localparam int  ACQ_CYCLES    = (ACQ_NS + CLK_PERIOD_NS - 1.0) / CLK_PERIOD_NS + 1;
	localparam real CFG_SETUP_NS  = 31.25;
	localparam int  CFG_SETUP_CYC = (CFG_SETUP_NS + CLK_PERIOD_NS - 1.0) / CLK_PERIOD_NS;
	localparam int  RD_SETUP_CYC  = 1;
	localparam int  CNT_W         = 5;
	// Configuration word fields
	localparam int  CFG_SEL_LO_BIT = 0;
	localparam int  CFG_SEL_HI_BIT = 1;
	localparam int  CFG_PSEUDO_BIT = 2;
	localparam int  CFG_SLEEP_BIT  = 3;
	localparam int  CFG_DACWR_BIT  = 11;
	localparam logic [DATA_W-1:0] CFG_RESET = 12'h000;
	localparam logic [DAC_W-1:0]  DAC_RESET = 10'h3ff;
	// Host register offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_CFG    = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_RESULT = 8'h0c;
	localparam logic [7:0] REG_DAC    = 8'h10;

	// Mux routing: returns {pos,neg} input index (0=p0pos,1=p0neg,2=p1pos,3=p1neg)
	function automatic logic [3:0] route(input logic hi, input logic lo, input logic pseudo);
		if (pseudo) begin
			unique case ({hi, lo})
				2'b01:   route = {2'd3, 2'd1};
				2'b10:   route = {2'd2, 2'd1};
				default: route = {2'd0, 2'd1};
			endcase
		end else begin
			route = (hi & lo) ? {2'd2, 2'd3} : {2'd0, 2'd1};
		end
	endfunction : route
endpackage : adc_ctrl_pkg

// ---- adc_link_if.sv ----
`timescale 1ns/1ps
// Purpose: Parallel link between host controller and converter control
// Assumes: Both ends on one clock; bus level resolved from enables
// Notes:   Host drives data on writes, device on reads
interface adc_link_if;
	import adc_ctrl_pkg::*;
	logic              convStart_n;
	logic              chipSel_n;
	logic              rd_n;
	logic              wr_n;
	logic              busy;
	logic [DATA_W-1:0] hostData;
	logic              hostDataOe;
	logic [DATA_W-1:0] devData;
	logic              devDataOe;
	logic [DATA_W-1:0] busLevel;
	assign busLevel = devDataOe ? devData : (hostDataOe ? hostData : '0);
	modport device (input convStart_n, chipSel_n, rd_n, wr_n, busLevel,
		output busy, devData, devDataOe);
	modport host (output convStart_n, chipSel_n, rd_n, wr_n, hostData, hostDataOe,
		input busy, busLevel);
endinterface : adc_link_if

// ---- adc_device_ctrl.sv ----
`timescale 1ns/1ps
// Purpose: Conversion sequencing, channel routing and DAC setting
// Assumes: Link pins asynchronous to clk; SAR cores modelled by sampled codes
// Notes:   Strobes are synchronised, so edges are seen two cycles late
// Behaviour
// - Both inputs sampled together, converted together
// - Conversion lasts thirteen clock periods
// - Busy rises on start strobe falling edge
// - Auto-sleep relaxes busy rise timing
// - Busy drops after fourteenth counted edge
// - Host reads one clock before busy
// - Start taken on next clean edge
// - Host avoids start rise near edges
// - Host holds config data before start
// - Host leaves acquisition gap between conversions
// - Differential or pseudo-differential input selection
// - Two select bits choose routing
// - Code 00 pair zero, 11 pair one
// - Ten-bit DAC code sets reference
// - Write strobe loads configuration
// - Hold on fall, convert next edge
// - Chip select high ignores, floats
// - Write captured on write rising edge
// - Read falling edge drives result
module adc_device_ctrl
	import adc_ctrl_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                arst_n,
	adc_link_if.device               link,
	input  wire logic [DATA_W-1:0]   convAInput [4],
	input  wire logic [DATA_W-1:0]   convBInput [4],
	output logic      [DAC_W-1:0]    referenceCode,
	output logic      [DATA_W-1:0]   configWord,
	output logic      [3:0]          routeA
);
	typedef enum logic [1:0] {IDLE, HOLD, CONVERT} conv_state_t;
	conv_state_t       state;
	logic [3:0]        convSync1, convSync2, convPrev;
	logic [CNT_W-1:0]  edgeCount;
	logic [DATA_W-1:0] heldA, heldB, resultA, resultB;
	logic              readSel;
	logic              startFall, wrRise, rdFall, active;

	// Sync vector: convStart_n, chipSel_n, rd_n, wr_n
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			convSync1 <= 4'hf;
			convSync2 <= 4'hf;
			convPrev  <= 4'hf;
		end else begin
			convSync1 <= {link.convStart_n, link.chipSel_n, link.rd_n, link.wr_n};
			convSync2 <= convSync1;
			convPrev  <= convSync2;
		end
	end
	assign active    = !convSync2[2];
	assign startFall = convPrev[3] & !convSync2[3];
	assign wrRise    = active & !convPrev[0] & convSync2[0];
	assign rdFall    = active & convPrev[1] & !convSync2[1];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state     <= IDLE;
			edgeCount <= '0;
			heldA     <= '0;
			heldB     <= '0;
			resultA   <= '0;
			resultB   <= '0;
		end else begin
			unique case (state)
				IDLE: if (startFall) begin
					// Both held at one instant from the current routing
					heldA <= convAInput[routeA[3:2]];
					heldB <= convBInput[routeA[3:2]];
					state <= HOLD;
				end
				HOLD: begin
					edgeCount <= 5'd1;
					state     <= CONVERT;
				end
				CONVERT: begin
					edgeCount <= edgeCount + 5'd1;
					if (edgeCount == 5'(BUSY_DROP_EDGE - 1)) begin
						resultA <= heldA;
						resultB <= heldB;
						state   <= IDLE;
					end
				end
				default: state <= IDLE;
			endcase
		end
	end
	// Sleep mode takes the same path; its rise timing is not guaranteed
	assign link.busy = (state != IDLE);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			configWord    <= CFG_RESET;
			referenceCode <= DAC_RESET;
		end else if (wrRise) begin
			if (link.busLevel[CFG_DACWR_BIT])
				referenceCode <= link.busLevel[DAC_W-1:0];
			else
				configWord <= link.busLevel;
		end
	end
	assign routeA = route(configWord[CFG_SEL_HI_BIT], configWord[CFG_SEL_LO_BIT],
		configWord[CFG_PSEUDO_BIT]);

	// Reads alternate A then B
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			readSel      <= 1'b0;
			link.devData <= '0;
		end else if (rdFall) begin
			link.devData <= readSel ? resultB : resultA;
			readSel      <= !readSel;
		end else if (startFall) begin
			readSel <= 1'b0;
		end
	end
	assign link.devDataOe = active & !convSync2[1];
endmodule : adc_device_ctrl

// ---- adc_link_monitor.sv ----
// Purpose: Assertions on the link between host end and converter end
// Assumes: One clock, asynchronous active-low reset
// Notes:   Sees link pins only; register-side effects are left to the bench
`timescale 1ns/1ps
module adc_link_monitor (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic convStart_n,
	input wire logic chipSel_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic busy,
	input wire logic hostDataOe,
	input wire logic devDataOe
);
	logic [4:0] busyCnt;

	// Counts busy cycles so that the full length can be checked without long repetitions
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busyCnt <= 5'h00;
		end else begin
			busyCnt <= busy ? busyCnt + 5'h01 : 5'h00;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence startSeen;
		$fell(convStart_n) && !busy;
	endsequence
	sequence busyRun;
		busy[*8];
	endsequence

	busy_rise_a: assert property (startSeen |-> ##[1:4] busy) else $error("busy late");
	busy_hold_a: assert property ($rose(busy) |-> busyRun) else $error("busy short");
	busy_len_a: assert property ($fell(busy) |-> busyCnt == 5'h0e) else $error("busy len");
	cs_float_a: assert property ($rose(devDataOe) |-> !chipSel_n) else $error("oe no cs");
	no_clash_a: assert property (!(hostDataOe && devDataOe)) else $error("bus clash");
	rd_drive_a: assert property ($fell(rd_n) && !chipSel_n |-> ##[1:4] devDataOe)
		else $error("no read data");
	wr_data_a: assert property ($rose(wr_n) |-> $past(hostDataOe)) else $error("wr no data");
	start_idle_a: assert property ($fell(convStart_n) |-> !busy) else $error("start busy");
	acq_gap_a: assert property ($fell(busy) |-> convStart_n[*2]) else $error("acq short");
	cfg_setup_a: assert property ($rose(wr_n) |-> convStart_n[*2]) else $error("cfg setup");
	rd_before_a: assert property ($fell(rd_n) |=> !$rose(busy)) else $error("rd late");
endmodule : adc_link_monitor

// ---- testbench.sv ----
// Purpose: Drives the host end over AHB-Lite and checks the converter end
// Assumes: Zero-wait slave; neg inputs held at zero so results equal pos codes
// Notes:   Inputs change mid-conversion to prove the sample is held
`timescale 1ns/1ps
module testbench;
	import adc_ctrl_pkg::*;
	logic              clk = 1'b0;
	logic              arst_n = 1'b0;
	logic              hsel = 1'b0;
	logic [31:0]       haddr = 32'h0;
	logic [1:0]        htrans = 2'b00;
	logic              hwrite = 1'b0;
	logic [2:0]        hsize = 3'b010;
	logic [31:0]       hwdata = 32'h0;
	logic              hreadyout;
	logic [31:0]       hrdata;
	logic [DATA_W-1:0] aIn [4] = '{default: 12'h000};
	logic [DATA_W-1:0] bIn [4] = '{default: 12'h000};
	logic [DAC_W-1:0]  refCode;
	logic [DATA_W-1:0] cfgWord;
	logic [3:0]        routeA;
	int                mismatches = 0;
	int                total_checks = 0;
	localparam logic [11:0] CFG_TAB [5] = '{12'h000, 12'h003, 12'h004, 12'h005, 12'h006};
	localparam logic [3:0]  EXP_RT [5]  = '{4'h1, 4'hb, 4'h1, 4'hd, 4'h9};

	always #25 clk = ~clk;

	adc_link_if link();
	adc_device_ctrl u_adc_device_ctrl (.clk(clk), .arst_n(arst_n), .link(link),
		.convAInput(aIn), .convBInput(bIn), .referenceCode(refCode), .configWord(cfgWord),
		.routeA(routeA));
	adc_host_ctrl u_adc_host_ctrl (.clk(clk), .arst_n(arst_n), .link(link), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata));
	adc_link_monitor u_adc_link_monitor (.clk(clk), .arst_n(arst_n),
		.convStart_n(link.convStart_n), .chipSel_n(link.chipSel_n), .rd_n(link.rd_n),
		.wr_n(link.wr_n), .busy(link.busy), .hostDataOe(link.hostDataOe),
		.devDataOe(link.devDataOe));

	task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h000000, addr};
		htrans <= 2'b10;
		hwrite <= wr;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask : ahb

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Polls the active flag; the bound keeps a stuck sequencer from hiding
	task automatic wait_idle();
		logic [31:0] s;
		s = 32'h1;
		for (int i = 0; i < 500 && s[0] !== 1'b0; i++) ahb(1'b0, REG_STATUS, 32'h0, s);
		chk({31'h0, s[0]}, 32'h0);
	endtask : wait_idle

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report

	initial begin
		#(50.0 * 40000);
		mismatches++;
		final_report();
	end

	initial begin
		logic [31:0] r;
		int p;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		chk({20'h0, cfgWord}, {20'h0, CFG_RESET});
		chk({22'h0, refCode}, {22'h0, DAC_RESET});
		$display("test reset done");
		for (int i = 0; i < 5; i++) begin
			ahb(1'b1, REG_CFG, {20'h0, CFG_TAB[i]}, r);
			ahb(1'b1, REG_CTRL, 32'h2, r);
			wait_idle();
			chk({20'h0, cfgWord}, {20'h0, CFG_TAB[i]});
			chk({28'h0, routeA}, {28'h0, EXP_RT[i]});
		end
		$display("test routing done");
		ahb(1'b1, REG_DAC, 32'h9fd, r);
		ahb(1'b1, REG_CTRL, 32'h4, r);
		wait_idle();
		chk({22'h0, refCode}, 32'h1fd);
		$display("test dac done");
		for (int k = 0; k < 2; k++) begin
			p = 2 * k;
			aIn[p] <= 12'h5a3 + k[11:0];
			bIn[p] <= 12'h3c7 + k[11:0];
			ahb(1'b1, REG_CFG, k ? 32'h3 : 32'h0, r);
			ahb(1'b1, REG_CTRL, 32'h2, r);
			wait_idle();
			ahb(1'b1, REG_CTRL, 32'h1, r);
			while (link.busy !== 1'b1) @(posedge clk);
			aIn[p] <= 12'hfff;
			bIn[p] <= 12'hfff;
			wait_idle();
			ahb(1'b0, REG_RESULT, 32'h0, r);
			chk(r, {4'h0, 12'h3c7 + k[11:0], 4'h0, 12'h5a3 + k[11:0]});
			aIn[p] <= 12'h000;
			bIn[p] <= 12'h000;
		end
		$display("test conversion done");
		final_report();
	end
endmodule : testbench
